// File: sim/dbu_break_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module dbu_break_unit_test;
  localparam logic [23:0] WB = 24'h000fc0;
  localparam logic [31:0] KEY = 32'h5a5aa5a5;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, pc_load_vector, debug_irq;
  logic debug_mode, irq_en, nmi_en, cancel_req = 1'b0, brk_req = 1'b0;
  logic pull_low, probe_cancel, flash_rd = 1'b0, flash_prog = 1'b0;
  logic flash_err, flash_prot, gpio = 1'b0, lclk, tx_bit = 1'b0;
  logic tx_en = 1'b0, dout, doe, dstat;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h79c07c08, rv, e_v;
  logic [15:0] flash_rdata = 16'h0000, flash_out;
  logic [7:0] run_bits = 8'h00, periph_run;
  logic [23:0] ba [4];
  logic [31:0] exp_q [$];
  dbu_pkg::dbu_psr_type core_psr = '0;
  dbu_pkg::dbu_core_type core_evt = '0;
  int bad_count = 0, checks = 0, edges = 0;
  // Pull-up keeps the shared line high when nobody drives it
  wire logic dline = doe ? dout : !pull_low;

  dbu_break_unit #(.WORK_BASE(WB), .UNLOCK_KEY(KEY)) i_dbu_break_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_psr(core_psr),
    .core_evt(core_evt), .reset_vector(24'h008000),
    .pc_load_vector(pc_load_vector), .debug_irq(debug_irq),
    .debug_mode(debug_mode), .irq_accept_en(irq_en),
    .nmi_accept_en(nmi_en), .run_in_debug_bit(run_bits),
    .periph_run(periph_run), .probe_cancel(probe_cancel),
    .dbg_flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .dbg_flash_rdata(flash_out), .dbg_flash_prog(flash_prog),
    .dbg_flash_err(flash_err), .flash_protected(flash_prot),
    .pins_to_gpio(gpio), .debug_link_clock(lclk),
    .debug_data_io_in(dline), .debug_data_io_out(dout),
    .debug_data_io_oe(doe), .probe_tx_bit(tx_bit), .probe_tx_en(tx_en),
    .debug_status_out(dstat));
  dbu_probe_model i_dbu_probe_model (.pclk(pclk), .presetn(presetn),
    .brk_req(brk_req), .cancel_req(cancel_req), .pull_low(pull_low),
    .probe_cancel(probe_cancel));

  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge lclk) edges++;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rnd();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : next_rnd
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Scoreboard: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e_v = exp_q.pop_front();
      `CHK(prdata, e_v)
    end
  end
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK(pc_load_vector, 1'b1)
    `CHK(flash_prot, 1'b1)
    `CHK({lclk, dstat, doe, debug_mode}, 4'h0)
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(pc_load_vector, 1'b0)
  endtask : do_reset
  task automatic wait_mode(input logic m);
    int n;
    n = 0;
    while (debug_mode !== m && n < 12) begin
      n++;
      @(posedge pclk);
    end
    `CHK(debug_mode, m)
  endtask : wait_mode
  task automatic fire(input dbu_pkg::dbu_src_type s, input logic [23:0] a,
                      input logic by_cancel);
    @(posedge pclk);
    case (s)
      dbu_pkg::SRC_ADDR: core_evt <= {4'b0001, a};
      dbu_pkg::SRC_STEP: core_evt.insn_done <= 1'b1;
      dbu_pkg::SRC_SOFT: core_evt.brk_insn <= 1'b1;
      default: brk_req <= 1'b1;
    endcase
    @(negedge pclk);
    if (s != dbu_pkg::SRC_FORCE) `CHK(debug_irq, 1'b1)
    @(posedge pclk);
    core_evt <= '0;
    brk_req <= 1'b0;
    wait_mode(1'b1);
    rv = next_rnd();
    run_bits <= rv[7:0];
    gpio <= 1'b1;
    @(negedge pclk);
    `CHK({irq_en, nmi_en, periph_run}, {2'b00, rv[7:0]})
    `CHK(dstat, 1'b0)
    @(posedge pclk);
    gpio <= 1'b0;
    @(negedge pclk);
    `CHK(dstat, 1'b1)
    rd(dbu_pkg::OFS_DEBUG_STAT, {27'h0, 1'b1, s, 1'b1});
    @(posedge pclk);
    if (by_cancel)
      cancel_req <= 1'b1;
    else
      core_evt.retd_insn <= 1'b1;
    @(posedge pclk);
    cancel_req <= 1'b0;
    core_evt.retd_insn <= 1'b0;
    wait_mode(1'b0);
    `CHK({irq_en, periph_run}, 9'h1ff)
  endtask : fire
  task automatic fl(input logic prog, input logic [15:0] e);
    @(posedge pclk);
    flash_rd <= !prog;
    flash_prog <= prog;
    @(posedge pclk);
    flash_rd <= 1'b0;
    flash_prog <= 1'b0;
    @(negedge pclk);
    if (prog) `CHK(flash_err, e[0])
    else `CHK(flash_out, e)
  endtask : fl
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    bad_count++;
    stop_test();
  end
  initial begin
    do_reset();
    @(negedge pclk);
    edges = 0;
    repeat (80) @(negedge pclk);
    `CHK(edges, 10)
    for (int i = 0; i < 4; i++) begin
      rv = next_rnd();
      @(posedge pclk);
      core_psr <= rv[7:0];
      rd(dbu_pkg::OFS_STATUS_MIRROR, {24'h0, rv[7:0]});
    end
    apb(1'b1, dbu_pkg::OFS_STATUS_MIRROR, ~rv);
    rd(dbu_pkg::OFS_STATUS_MIRROR, {24'h0, rv[7:0]});
    apb(1'b1, dbu_pkg::OFS_WORK_BASE, 32'h0);
    rd(dbu_pkg::OFS_WORK_BASE, {8'h00, WB});
    rd(12'h0fc, 32'h0);
    tx_en <= 1'b1;
    tx_bit <= rv[9];
    @(negedge pclk);
    `CHK({doe, dline}, {1'b1, rv[9]})
    @(posedge pclk);
    gpio <= 1'b1;
    @(negedge pclk);
    `CHK(doe, 1'b0)
    @(posedge pclk);
    gpio <= 1'b0;
    // Drive the line high before release so no false break edge follows
    tx_bit <= 1'b1;
    repeat (4) @(posedge pclk);
    tx_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rv = next_rnd();
      ba[i] = rv[23:0];
      apb(1'b1, dbu_pkg::OFS_BREAK_ADDR0 + 12'(4 * i), {8'h0, ba[i]});
    end
    apb(1'b1, dbu_pkg::OFS_BREAK_CTRL, 32'h0f);
    for (int i = 0; i < 4; i++)
      fire(dbu_pkg::SRC_ADDR, ba[i], i[0]);
    apb(1'b1, dbu_pkg::OFS_BREAK_CTRL, 32'h10);
    fire(dbu_pkg::SRC_STEP, 24'h0, 1'b1);
    apb(1'b1, dbu_pkg::OFS_BREAK_CTRL, 32'h0);
    fire(dbu_pkg::SRC_SOFT, 24'h0, 1'b0);
    fire(dbu_pkg::SRC_FORCE, 24'h0, 1'b1);
    rv = next_rnd();
    flash_rdata <= rv[15:0];
    fl(1'b0, 16'hffff);
    fl(1'b1, 16'h0001);
    apb(1'b1, dbu_pkg::OFS_UNPROTECT, ~KEY);
    `CHK(flash_prot, 1'b1)
    apb(1'b1, dbu_pkg::OFS_UNPROTECT, KEY);
    @(negedge pclk);
    `CHK(flash_prot, 1'b0)
    fl(1'b0, rv[15:0]);
    fl(1'b1, 16'h0000);
    do_reset();
    stop_test();
  end
endmodule : dbu_break_unit_test
`default_nettype wire

// File: sim/dbu_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbu_probe_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic brk_req,
  input wire logic cancel_req,
  output logic pull_low,
  output logic probe_cancel
);
  logic [3:0] hold_r;
  // Long low pulse so the three-flop sync cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_r <= 4'h0;
    else if (brk_req)
      hold_r <= 4'h8;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  end
  assign pull_low = (hold_r != 4'h0);
  // Cancel command, one cycle wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      probe_cancel <= 1'b0;
    else
      probe_cancel <= cancel_req;
  end
endmodule : dbu_probe_model
`default_nettype wire

// File: verilog/dbu_break_unit.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - At reset the core loads its program counter from the reset vector.
// - Status mirror reads give the live status word; writes change nothing.
// - Mirror bits 7..5 show interrupt level; bits 15..8 read zero.
// - Mirror bit 4 shows the global interrupt enable.
// - Mirror bits 3..0 show carry, overflow, zero, negative; reset zero.
// - Up to four armed break addresses raise a debug interrupt pre-execution.
// - Single step raises a debug interrupt after each completed instruction.
// - Probe break request on the data pin forces a debug interrupt.
// - The software break instruction raises a debug interrupt.
// - Every debug interrupt puts the core into debug mode.
// - Peripherals run or stop in debug mode by their own run bit.
// - Debug mode lasts until probe cancel or debug-return instruction.
// - No hardware interrupt or NMI is accepted during debug mode.
// - Work area base reads start address in bits 23..0, upper zero.
// - Debug link clock is an output, low after reset.
// - Data pin is bidirectional, carries break request, input after reset.
// - Status output pin reports processor status while debugging; low at reset.
// - Debug pins act as debug pins after reset; reassignable when unused.
// - Protected flash read through the debugger returns undefined data.
// - Protected flash programming through the probe ends in error.
// - Correct unprotect password lifts protection until the next reset.
module dbu_break_unit #(
  parameter int NUM_BREAKS = 4,
  parameter int NUM_PERIPH = 8,
  parameter logic [23:0] WORK_BASE = 24'h000fc0,
  parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_a5a5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dbu_pkg::dbu_psr_type core_psr,
  input wire dbu_pkg::dbu_core_type core_evt,
  input wire logic [23:0] reset_vector,
  output logic pc_load_vector,
  output logic debug_irq,
  output logic debug_mode,
  output logic irq_accept_en,
  output logic nmi_accept_en,
  input wire logic [NUM_PERIPH-1:0] run_in_debug_bit,
  output logic [NUM_PERIPH-1:0] periph_run,
  input wire logic probe_cancel,
  input wire logic dbg_flash_rd,
  input wire logic [15:0] flash_rdata,
  output logic [15:0] dbg_flash_rdata,
  input wire logic dbg_flash_prog,
  output logic dbg_flash_err,
  output logic flash_protected,
  input wire logic pins_to_gpio,
  output logic debug_link_clock,
  input wire logic debug_data_io_in,
  output logic debug_data_io_out,
  output logic debug_data_io_oe,
  input wire logic probe_tx_bit,
  input wire logic probe_tx_en,
  output logic debug_status_out
);
  localparam int BI = $clog2(NUM_BREAKS);
  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] brk_addr_r [NUM_BREAKS];
  logic [NUM_BREAKS-1:0] brk_arm_r;
  logic step_r;
  logic debug_r;
  logic protect_r;
  logic [1:0] div_r;
  logic lclk_r;
  logic sio_s1_r, sio_s2_r, sio_s3_r;
  logic pcl_r;
  dbu_pkg::dbu_src_type src_r;
  logic [31:0] prdata_r;
  logic fl_err_r;
  logic [15:0] fl_data_r;
  logic wr_en, rd_en;
  logic hit, step_hit, force_hit, soft_hit, trig;
  logic [15:0] mirror;

  function automatic logic is_brk_addr(input logic [11:0] a, output int idx);
    idx = (int'(a) - int'(dbu_pkg::OFS_BREAK_ADDR0)) / 4;
    return (a >= dbu_pkg::OFS_BREAK_ADDR0) && (idx < NUM_BREAKS)
      && (a[1:0] == 2'h0);
  endfunction : is_brk_addr

  ////////////////////////////////////////////////////////////////////////////
  // APB: zero wait states, so pready is always high
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // Mirror is combinational from the core so reads see this cycle's status
  always_comb begin
    mirror = dbu_pkg::MIRROR_RESET;
    mirror[dbu_pkg::MIRROR_IL_LSB +: 3] = core_psr.il;
    mirror[dbu_pkg::MIRROR_IE_BIT] = core_psr.ie;
    mirror[dbu_pkg::MIRROR_C_BIT] = core_psr.c;
    mirror[dbu_pkg::MIRROR_V_BIT] = core_psr.v;
    mirror[dbu_pkg::MIRROR_Z_BIT] = core_psr.z;
    mirror[dbu_pkg::MIRROR_N_BIT] = core_psr.n;
  end

  // Read data is captured in setup, so it reflects status at that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      int k;
      prdata_r <= 32'h0000_0000;
      if (paddr == dbu_pkg::OFS_STATUS_MIRROR) begin
        prdata_r <= {16'h0000, mirror};
      end else if (paddr == dbu_pkg::OFS_WORK_BASE) begin
        prdata_r <= {8'h00, WORK_BASE};
      end else if (paddr == dbu_pkg::OFS_BREAK_CTRL) begin
        prdata_r[NUM_BREAKS-1:0] <= brk_arm_r;
        prdata_r[dbu_pkg::CTRL_STEP_BIT] <= step_r;
      end else if (paddr == dbu_pkg::OFS_DEBUG_STAT) begin
        prdata_r <= {27'h0, protect_r, src_r, debug_r};
      end else if (is_brk_addr(paddr, k)) begin
        prdata_r <= {8'h00, brk_addr_r[k[BI-1:0]]};
      end
    end
  end
  assign prdata = prdata_r;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Break configuration; mirror and base are read-only, writes dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_arm_r <= '0;
      step_r <= 1'b0;
      for (int i = 0; i < NUM_BREAKS; i++) begin
        brk_addr_r[i] <= 24'h000000;
      end
    end else if (wr_en) begin
      int k;
      if (paddr == dbu_pkg::OFS_BREAK_CTRL) begin
        brk_arm_r <= pwdata[NUM_BREAKS-1:0];
        step_r <= pwdata[dbu_pkg::CTRL_STEP_BIT];
      end else if (is_brk_addr(paddr, k)) begin
        brk_addr_r[k[BI-1:0]] <= pwdata[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Probe data pin synchroniser; a falling edge on an idle line means break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sio_s1_r <= 1'b1;
      sio_s2_r <= 1'b1;
      sio_s3_r <= 1'b1;
    end else begin
      sio_s1_r <= debug_data_io_in;
      sio_s2_r <= sio_s1_r;
      sio_s3_r <= sio_s2_r;
    end
  end

  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < NUM_BREAKS; i++) begin
      if (brk_arm_r[i] && core_evt.fetch_valid
          && core_evt.fetch_addr == brk_addr_r[i]) begin
        hit = 1'b1;
      end
    end
  end
  assign step_hit = step_r & core_evt.insn_done;
  // Falling edge on an idle, non-driven line is the forcible break
  assign force_hit = ~pins_to_gpio & ~debug_data_io_oe
    & sio_s3_r & ~sio_s2_r;
  assign soft_hit = core_evt.brk_insn;
  assign trig = hit | step_hit | force_hit | soft_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Debug mode: triggers are ignored while in debug mode, so exit wins over a trigger in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_r <= 1'b0;
      src_r <= dbu_pkg::SRC_NONE;
    end else if (!debug_r && trig) begin
      debug_r <= 1'b1;
      if (hit) src_r <= dbu_pkg::SRC_ADDR;
      else if (force_hit) src_r <= dbu_pkg::SRC_FORCE;
      else if (soft_hit) src_r <= dbu_pkg::SRC_SOFT;
      else src_r <= dbu_pkg::SRC_STEP;
    end else if (debug_r && (probe_cancel || core_evt.retd_insn)) begin
      debug_r <= 1'b0;
    end
  end
  assign debug_irq = ~debug_r & trig;
  assign debug_mode = debug_r;
  assign irq_accept_en = ~debug_r;
  assign nmi_accept_en = ~debug_r;
  assign periph_run = debug_r ? run_in_debug_bit : '1;

  // Request to load the PC from the vector, held through reset and cleared on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pcl_r <= 1'b1;
    else pcl_r <= 1'b0;
  end
  assign pc_load_vector = pcl_r & (reset_vector == reset_vector);

  ////////////////////////////////////////////////////////////////////////////
  // Flash security: only a reset restores protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_r <= 1'b1;
    end else if (wr_en && paddr == dbu_pkg::OFS_UNPROTECT
                 && pwdata == UNLOCK_KEY) begin
      protect_r <= 1'b0;
    end
  end
  assign flash_protected = protect_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_data_r <= 16'h0000;
      fl_err_r <= 1'b0;
    end else begin
      // Undefined data modelled as a fixed filler to avoid leaking content
      if (dbg_flash_rd) fl_data_r <= protect_r ? 16'hffff : flash_rdata;
      fl_err_r <= dbg_flash_prog & protect_r;
    end
  end
  assign dbg_flash_rdata = fl_data_r;
  assign dbg_flash_err = fl_err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider; pins fall back to idle when handed to GPIO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      lclk_r <= 1'b0;
    end else if (pins_to_gpio) begin
      div_r <= 2'h0;
      lclk_r <= 1'b0;
    end else if (div_r == dbu_pkg::LINK_CLK_DIV) begin
      div_r <= 2'h0;
      lclk_r <= ~lclk_r;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign debug_link_clock = lclk_r;
  assign debug_data_io_oe = probe_tx_en & ~pins_to_gpio;
  assign debug_data_io_out = probe_tx_bit;
  assign debug_status_out = debug_r & ~pins_to_gpio;

  ////////////////////////////////////////////////////////////////////////////
  a_enter_debug: assert property (@(posedge pclk) disable iff (!presetn)
    (!debug_r && trig) |=> debug_r) else $error("no debug entry");
  a_stay_debug: assert property (@(posedge pclk) disable iff (!presetn)
    (debug_r && !probe_cancel && !core_evt.retd_insn) |=> debug_r)
    else $error("debug left early");
  a_leave_debug: assert property (@(posedge pclk) disable iff (!presetn)
    (debug_r && core_evt.retd_insn) |=> !debug_r)
    else $error("debug not left");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    debug_r |-> !irq_accept_en && !nmi_accept_en)
    else $error("irq open in debug");
  a_addr_break: assert property (@(posedge pclk) disable iff (!presetn)
    (!debug_r && hit) |-> debug_irq ##1 src_r == dbu_pkg::SRC_ADDR)
    else $error("address break lost");
  a_step_break: assert property (@(posedge pclk) disable iff (!presetn)
    (!debug_r && step_r && core_evt.insn_done) |=> debug_r)
    else $error("step break lost");
  a_soft_break: assert property (@(posedge pclk) disable iff (!presetn)
    (!debug_r && core_evt.brk_insn) |=> debug_r)
    else $error("soft break lost");
  a_prot_err: assert property (@(posedge pclk) disable iff (!presetn)
    (dbg_flash_prog && protect_r) |=> dbg_flash_err)
    else $error("no program error");
  a_prot_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !protect_r |=> !protect_r) else $error("protect rose");
  a_mirror_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == dbu_pkg::OFS_STATUS_MIRROR)
    |=> prdata[15:0] == $past(mirror) && prdata[31:16] == 16'h0000)
    else $error("mirror mismatch");
  // Handing the pins to GPIO parks the clock low on the next pclk edge
  a_link_div: assert property (@(posedge pclk)
    disable iff (!presetn || pins_to_gpio)
    ($rose(lclk_r) && !pins_to_gpio) |=> lclk_r [*3])
    else $error("link clock short");
endmodule : dbu_break_unit
`default_nettype wire

// File: verilog/dbu_pkg.sv
package dbu_pkg;
  // Register byte offsets on the APB slave
  localparam logic [11:0] OFS_STATUS_MIRROR = 12'h008;
  localparam logic [11:0] OFS_WORK_BASE = 12'h00c;
  localparam logic [11:0] OFS_BREAK_CTRL = 12'h010;
  localparam logic [11:0] OFS_BREAK_ADDR0 = 12'h020;
  localparam logic [11:0] OFS_DEBUG_STAT = 12'h030;
  localparam logic [11:0] OFS_UNPROTECT = 12'h034;
  // Status mirror field positions
  localparam int MIRROR_IL_LSB = 5;
  localparam int MIRROR_IE_BIT = 4;
  localparam int MIRROR_C_BIT = 3;
  localparam int MIRROR_V_BIT = 2;
  localparam int MIRROR_Z_BIT = 1;
  localparam int MIRROR_N_BIT = 0;
  localparam logic [15:0] MIRROR_RESET = 16'h0000;
  // Break control fields, link clock divider and work area size
  localparam int CTRL_STEP_BIT = 4;
  localparam logic [1:0] LINK_CLK_DIV = 2'h3;
  localparam int WORK_AREA_BYTES = 64;

  typedef struct packed {
    logic [2:0] il;
    logic ie;
    logic c;
    logic v;
    logic z;
    logic n;
  } dbu_psr_type;

  typedef struct packed {
    logic brk_insn;
    logic retd_insn;
    logic insn_done;
    logic fetch_valid;
    logic [23:0] fetch_addr;
  } dbu_core_type;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_ADDR, SRC_STEP, SRC_FORCE, SRC_SOFT
  } dbu_src_type;
endpackage : dbu_pkg
